/* File: core/pss_pkg.sv */
// package for the controller system status word bank
package pss_pkg;
   // register indices as printed; byte address is four times the index
   localparam logic [7:0] IDX_ALLOC = 8'h16;
   localparam logic [7:0] IDX_PWROFF = 8'h17;
   localparam logic [7:0] IDX_ERRCODE = 8'h18;
   localparam logic [7:0] IDX_TRACE = 8'h19;
   localparam logic [7:0] IDX_MAXCYC = 8'h1a;
   localparam logic [7:0] IDX_CURCYC = 8'h1b;
   localparam logic [7:0] IDX_LIMIT = 8'h1c;
   localparam logic [7:0] IDX_MONSET = 8'h1d;
   localparam logic [7:0] IDX_IRQSTAT = 8'h1e;
   localparam logic [7:0] IDX_IRQMASK = 8'h1f;
   localparam logic [7:0] IDX_CTRL = 8'h20;
   // error-word and trace-word bit positions
   localparam int BIT_PWRUP_ERR = 0;
   localparam int BIT_START_ERR = 1;
   localparam int BIT_RUN_ERR = 2;
   localparam int BIT_LONG_CYC = 5;
   localparam int BIT_SAMPLE_START = 15;
   // bus error codes
   localparam logic [7:0] CODE_OUT_BASE = 8'h80;
   localparam logic [7:0] CODE_SLOT1 = 8'hf0;
   localparam logic [7:0] CODE_SLOT2 = 8'hf1;
   localparam logic [7:0] CODE_TERM = 8'hff;
   // bus error kinds
   typedef enum logic [2:0] {
      BE_IN = 3'b000,
      BE_OUT = 3'b001,
      BE_SLOT1 = 3'b010,
      BE_SLOT2 = 3'b011,
      BE_TERM = 3'b100
   } pss_buserr_t;
   // monitoring-time settings
   typedef enum logic [1:0] {
      MON_DEFAULT = 2'b00,
      MON_10MS = 2'b01,
      MON_100MS = 2'b10,
      MON_1S = 2'b11
   } pss_mon_t;
   // cycle time units in microseconds
   localparam int UNIT_FINE_US = 100;
   localparam int UNIT_MID_US = 1000;
   localparam int UNIT_COARSE_US = 10000;
   localparam int CLK_MHZ = 20;
   localparam int TICK_FINE = UNIT_FINE_US * CLK_MHZ;
   localparam int TICK_MID = UNIT_MID_US * CLK_MHZ;
   localparam int TICK_COARSE = UNIT_COARSE_US * CLK_MHZ;
   localparam logic [15:0] BCD_ZERO = 16'h0000;
   localparam logic [15:0] BCD_MAX = 16'h9999;
   localparam logic [4:0] IRQ_RESET = 5'h00;
endpackage : pss_pkg

/* File: core/pss_status_words.sv */
// system status word bank with apb slave and interrupt
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
module pss_status_words #(
   parameter int TICK_FINE_P = pss_pkg::TICK_FINE,
   parameter int TICK_MID_P = pss_pkg::TICK_MID,
   parameter int TICK_COARSE_P = pss_pkg::TICK_COARSE
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic allocValid,
   input wire logic [3:0] inWordCount,
   input wire logic [3:0] outWordCount,
   input wire logic unitOverErr,
   input wire logic powerOffEvent,
   input wire logic pwrupSetErr,
   input wire logic startSetErr,
   input wire logic runSetErr,
   input wire logic portPeriphChg,
   input wire logic portSerialChg,
   input wire logic busErr,
   input wire pss_pkg::pss_buserr_t busErrKind,
   input wire logic [3:0] busErrWord,
   input wire logic running,
   input wire logic scanEnd,
   input wire logic [6:0] traceIn,
   output logic irq
);
   import pss_pkg::*;

   logic [7:0] inAlloc_ff, outAlloc_ff;
   logic [15:0] pwrOff_ff, maxCyc_ff, curCyc_ff, limit_ff, cycCnt_ff;
   logic [5:0] errFlags_ff;
   logic [7:0] errCode_ff;
   logic [15:0] trace_ff;
   pss_mon_t monSet_ff;
   logic [4:0] irqStat_ff, irqMask_ff;
   logic sampleStart_ff;
   logic [17:0] tickCnt_ff;
   logic unitTick;
   logic [17:0] tickLimit;
   logic wrEn, rdEn, mapped;
   logic [7:0] idx;
   logic [4:0] events;

   function automatic logic [7:0] bin2bcd(input logic [3:0] v);
      bin2bcd = (v > 4'd9) ? {4'h1, v - 4'd10} : {4'h0, v};
   endfunction : bin2bcd

   function automatic logic [15:0] bcdInc(input logic [15:0] v);
      logic [15:0] r;
      r = v;
      if (v == BCD_MAX) begin
         r = BCD_ZERO;
      end else if (v[3:0] != 4'h9) begin
         r[3:0] = v[3:0] + 4'h1;
      end else if (v[7:4] != 4'h9) begin
         r[7:0] = {v[7:4] + 4'h1, 4'h0};
      end else if (v[11:8] != 4'h9) begin
         r[11:0] = {v[11:8] + 4'h1, 8'h00};
      end else begin
         r = {v[15:12] + 4'h1, 12'h000};
      end
      bcdInc = r;
   endfunction : bcdInc

   ////////////////////////////////////////////////////////////////////////////
   // apb decode: zero-wait slave, unmapped answers pslverr
   assign idx = paddr[9:2];
   assign mapped = (idx >= IDX_ALLOC) && (idx <= IDX_CTRL);
   // a write lands only at the access edge, where pready is seen high
   assign wrEn = psel && penable && pwrite && mapped && pready;
   assign rdEn = psel && !penable;

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !mapped;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         prdata <= 32'h0000_0000;
      end else if (rdEn) begin
         unique case (idx)
            IDX_ALLOC: prdata <= {16'h0000, outAlloc_ff, inAlloc_ff};
            IDX_PWROFF: prdata <= {16'h0000, pwrOff_ff};
            IDX_ERRCODE: prdata <= {16'h0000, errCode_ff, 2'b00, errFlags_ff};
            IDX_TRACE: prdata <= {16'h0000, sampleStart_ff, trace_ff[14:0]};
            IDX_MAXCYC: prdata <= {16'h0000, maxCyc_ff};
            IDX_CURCYC: prdata <= {16'h0000, curCyc_ff};
            IDX_LIMIT: prdata <= {16'h0000, limit_ff};
            IDX_MONSET: prdata <= {30'h0000_0000, monSet_ff};
            IDX_IRQSTAT: prdata <= {27'h000_0000, irqStat_ff};
            IDX_IRQMASK: prdata <= {27'h000_0000, irqMask_ff};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // word allocation
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         inAlloc_ff <= 8'h00;
         outAlloc_ff <= 8'h00;
      end else if (unitOverErr) begin
         inAlloc_ff <= 8'h00;
         outAlloc_ff <= 8'h00;
      end else if (allocValid) begin
         inAlloc_ff <= bin2bcd(inWordCount);
         outAlloc_ff <= bin2bcd(outWordCount);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // power-off counter; an event in the clear cycle still counts from zero
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         pwrOff_ff <= BCD_ZERO;
      end else if (wrEn && idx == IDX_PWROFF && pwdata[15:0] == BCD_ZERO
                   && pstrb[1:0] == 2'b11) begin
         pwrOff_ff <= powerOffEvent ? bcdInc(BCD_ZERO) : BCD_ZERO;
      end else if (powerOffEvent) begin
         pwrOff_ff <= bcdInc(pwrOff_ff);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // settings and bus error word; flags 0-4 are live levels from the scan logic, the long-cycle flag updates only at scan end
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         errFlags_ff <= 6'h00;
      end else begin
         errFlags_ff[BIT_PWRUP_ERR] <= pwrupSetErr;
         errFlags_ff[BIT_START_ERR] <= startSetErr;
         errFlags_ff[BIT_RUN_ERR] <= runSetErr;
         errFlags_ff[3] <= portPeriphChg;
         errFlags_ff[4] <= portSerialChg;
         if (scanEnd) begin
            errFlags_ff[BIT_LONG_CYC] <= cycCnt_ff > limit_ff;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         errCode_ff <= 8'h00;
      end else if (busErr) begin
         unique case (busErrKind)
            BE_IN: errCode_ff <= bin2bcd(busErrWord);
            BE_OUT: errCode_ff <= CODE_OUT_BASE | bin2bcd(busErrWord);
            BE_SLOT1: errCode_ff <= CODE_SLOT1;
            BE_SLOT2: errCode_ff <= CODE_SLOT2;
            BE_TERM: errCode_ff <= CODE_TERM;
            default: errCode_ff <= errCode_ff;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // trace word: bit 15 is written by any apb write to the trace index with pstrb[1] set
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         trace_ff <= 16'h0000;
         sampleStart_ff <= 1'b0;
      end else begin
         trace_ff <= {1'b0, traceIn[6:4], 3'b000, traceIn[3], 8'h00};
         if (wrEn && idx == IDX_TRACE && pstrb[1]) begin
            sampleStart_ff <= pwdata[BIT_SAMPLE_START];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // settings registers
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         limit_ff <= BCD_MAX;
         monSet_ff <= MON_DEFAULT;
         irqMask_ff <= IRQ_RESET;
      end else if (wrEn) begin
         if (idx == IDX_LIMIT && pstrb[1:0] == 2'b11) limit_ff <= pwdata[15:0];
         if (idx == IDX_MONSET && pstrb[0]) monSet_ff <= pss_mon_t'(pwdata[1:0]);
         if (idx == IDX_IRQMASK && pstrb[0]) irqMask_ff <= pwdata[4:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // cycle time measurement; unit tick divider follows monitoring setting
   always_comb begin
      unique case (monSet_ff)
         MON_100MS: tickLimit = 18'(TICK_MID_P - 1);
         MON_1S: tickLimit = 18'(TICK_COARSE_P - 1);
         default: tickLimit = 18'(TICK_FINE_P - 1);
      endcase
   end
   assign unitTick = running && (tickCnt_ff >= tickLimit);

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         tickCnt_ff <= 18'h00000;
      end else if (!running || scanEnd || unitTick) begin
         tickCnt_ff <= 18'h00000;
      end else begin
         tickCnt_ff <= tickCnt_ff + 18'h00001;
      end
   end

   // saturating counter at 9999 avoids wrap into a false short cycle
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         cycCnt_ff <= BCD_ZERO;
      end else if (scanEnd) begin
         cycCnt_ff <= BCD_ZERO;
      end else if (unitTick && cycCnt_ff != BCD_MAX) begin
         cycCnt_ff <= bcdInc(cycCnt_ff);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         curCyc_ff <= BCD_ZERO;
         maxCyc_ff <= BCD_ZERO;
      end else if (running && scanEnd) begin
         curCyc_ff <= cycCnt_ff;
         if (cycCnt_ff > maxCyc_ff) maxCyc_ff <= cycCnt_ff;
      end
      // no clear when running drops: value held
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupts: bus error, long cycle, run/start/power-up setting errors
   assign events = {busErr,
                    scanEnd && (cycCnt_ff > limit_ff),
                    runSetErr && !errFlags_ff[BIT_RUN_ERR],
                    startSetErr && !errFlags_ff[BIT_START_ERR],
                    pwrupSetErr && !errFlags_ff[BIT_PWRUP_ERR]};

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         irqStat_ff <= IRQ_RESET;
      end else begin
         // set beats a simultaneous write-one clear
         if (wrEn && idx == IDX_IRQSTAT && pstrb[0]) begin
            irqStat_ff <= (irqStat_ff & ~pwdata[4:0]) | events;
         end else begin
            irqStat_ff <= irqStat_ff | events;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irqStat_ff & irqMask_ff);
      end
   end
endmodule : pss_status_words

/* File: verification/pss_status_words_asserts.sv */
// checker for the status word bank at its apb and status ports
`timescale 1ns/1ps
module pss_status_words_asserts
   import pss_pkg::*;
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic unitOverErr
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   logic rdv;
   logic [7:0] idx;
   assign rdv = pready && !pwrite && !pslverr;
   assign idx = paddr[9:2];
   function automatic logic isbcd(input logic [15:0] v);
      isbcd = v[3:0] < 4'ha && v[7:4] < 4'ha && v[11:8] < 4'ha && v[15:12] < 4'ha;
   endfunction : isbcd
   property p_ack; psel && !penable |=> pready && penable; endproperty
   a_ack: assert property (p_ack) else $error("no ready after setup");
   property p_rdy; pready |-> psel && penable && $past(psel); endproperty
   a_rdy: assert property (p_rdy) else $error("ready outside access");
   property p_bad;
      psel && !penable && (paddr[9:2] < IDX_ALLOC || paddr[9:2] > IDX_CTRL) |=> pslverr;
   endproperty
   a_bad: assert property (p_bad) else $error("unmapped not refused");
   property p_top; pready && !pwrite |-> prdata[31:16] == 16'h0000; endproperty
   a_top: assert property (p_top) else $error("upper half not zero");
   property p_alloc;
      unitOverErr[*3] ##0 (rdv && idx == IDX_ALLOC) |-> prdata[15:0] == 16'h0000;
   endproperty
   a_alloc: assert property (p_alloc) else $error("counts not forced");
   property p_pwr; rdv && idx == IDX_PWROFF |-> isbcd(prdata[15:0]); endproperty
   a_pwr: assert property (p_pwr) else $error("counter not bcd");
   property p_cur; rdv && idx == IDX_CURCYC |-> isbcd(prdata[15:0]); endproperty
   a_cur: assert property (p_cur) else $error("cycle time not bcd");
   property p_code;
      rdv && idx == IDX_ERRCODE |-> prdata[7:6] == 2'b00 && (prdata[15:8] <= 8'h15
         || (prdata[15:8] >= 8'h80 && prdata[15:8] <= 8'h95) || prdata[15:8] >= 8'hf0);
   endproperty
   a_code: assert property (p_code) else $error("bad error code");
endmodule : pss_status_words_asserts
bind pss_status_words pss_status_words_asserts u_chk (.clk_sys(clk_sys), .nrst(nrst),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .unitOverErr(unitOverErr));

/* File: verification/pss_prog_host.sv */
// apb master standing for the user program and programming device
`timescale 1ns/1ps
module pss_prog_host (
   input wire logic clk_sys,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata,
   output logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   output logic hang
);
   initial begin
      {psel, penable, pwrite, paddr, pwdata, pstrb, hang} = '0;
   end
   // program code never writes the sampling start bit; only reads touch the trace word
   task xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
         output logic [31:0] rd, output logic err);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= wd;
      pstrb <= 4'hf;
      @(posedge clk_sys);
      penable <= 1'b1;
      for (int n = 0; n < 20; n++) begin
         @(posedge clk_sys);
         if (pready) break;
         if (n == 19) hang <= 1'b1;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
endmodule : pss_prog_host

/* File: verification/plc_system_status_words_test.sv */
// self-checking bench for the status word bank
`timescale 1ns/1ps
module plc_system_status_words_test;
   import pss_pkg::*;
   logic clk_sys, nrst, allocValid, unitOverErr, powerOffEvent, pwrupSetErr, startSetErr;
   logic runSetErr, portPeriphChg, portSerialChg, busErr, running, scanEnd;
   logic psel, penable, pwrite, pready, pslverr, irq, hang, e;
   logic [3:0] inWordCount, outWordCount, busErrWord, pstrb;
   logic [6:0] traceIn;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, d;
   logic [15:0] x;
   pss_buserr_t busErrKind;
   int err_count, cmp_count, pc, a, b, seed;
   int ut[4] = '{4, 4, 8, 16};
   pss_status_words #(.TICK_FINE_P(4), .TICK_MID_P(8), .TICK_COARSE_P(16)) dut (
      .clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .allocValid(allocValid), .inWordCount(inWordCount),
      .outWordCount(outWordCount), .unitOverErr(unitOverErr), .powerOffEvent(powerOffEvent),
      .pwrupSetErr(pwrupSetErr), .startSetErr(startSetErr), .runSetErr(runSetErr),
      .portPeriphChg(portPeriphChg), .portSerialChg(portSerialChg), .busErr(busErr),
      .busErrKind(busErrKind), .busErrWord(busErrWord), .running(running),
      .scanEnd(scanEnd), .traceIn(traceIn), .irq(irq));
   pss_prog_host host (.clk_sys(clk_sys), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .hang(hang));
   //////////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   function automatic logic [15:0] bcd(input int v);
      bcd = 16'h0;
      for (int i = 0; i < 4; i++) begin
         bcd[i*4 +: 4] = 4'(v % 10);
         v = v / 10;
      end
   endfunction : bcd
   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task rd(input logic [7:0] idx, input logic [31:0] exp);
      host.xfer(1'b0, idx, 32'h0, d, e);
      chk({31'h0, e}, {31'h0, idx < IDX_ALLOC || idx > IDX_CTRL});
      chk(d, exp);
   endtask : rd
   // cycle counts may land one tick either side, depending on scan phase
   task rdn(input logic [7:0] idx, input int n);
      host.xfer(1'b0, idx, 32'h0, d, e);
      if (d === bcd(n - 1) || d === bcd(n + 1)) d = bcd(n);
      chk(d, bcd(n));
   endtask : rdn
   task wr(input logic [7:0] idx, input logic [31:0] v);
      host.xfer(1'b1, idx, v, d, e);
   endtask : wr
   task tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : tick
   task scan(input int n);
      tick(n);
      scanEnd <= 1'b1;
      tick(1);
      scanEnd <= 1'b0;
   endtask : scan
   task test_done;
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : test_done
   always @(posedge hang) begin
      err_count++;
      test_done();
   end
   //////////////////////////////////////////////////////////////////////////////////////
   initial begin
      seed = 33894;
      {nrst, allocValid, unitOverErr, powerOffEvent, pwrupSetErr, startSetErr} = '0;
      {runSetErr, portPeriphChg, portSerialChg, busErr, running, scanEnd} = '0;
      {inWordCount, outWordCount, busErrWord, traceIn} = '0;
      busErrKind = BE_IN;
      tick(4);
      nrst <= 1'b1;
      rd(IDX_PWROFF, 0);
      rd(IDX_LIMIT, 32'h9999);
      rd(8'h21, 0);
      rd(8'h00, 0);
      for (int k = 0; k < 4; k++) begin
         a = {$random(seed)} % 16;
         b = {$random(seed)} % 16;
         inWordCount <= 4'(a);
         outWordCount <= 4'(b);
         allocValid <= 1'b1;
         scan(1);
         allocValid <= 1'b0;
         rd(IDX_ALLOC, bcd(b * 100 + a));
      end
      unitOverErr <= 1'b1;
      allocValid <= 1'b1;
      rd(IDX_ALLOC, 0);
      {unitOverErr, allocValid} <= 2'b00;
      for (int k = 1; k <= 10004; k++) begin
         if (k == 4) wr(IDX_PWROFF, 32'h1234);
         if (k == 5) wr(IDX_PWROFF, 32'h0);
         if (k == 5) pc = 0;
         powerOffEvent <= 1'b1;
         tick(1);
         powerOffEvent <= 1'b0;
         tick(1);
         pc = (pc + 1) % 10000;
         if (k < 5 || k > 10001) rd(IDX_PWROFF, bcd(pc));
      end
      {pwrupSetErr, startSetErr, runSetErr, portPeriphChg, portSerialChg} <= 5'h1f;
      traceIn <= 7'($random(seed));
      rd(IDX_ERRCODE, 32'h1f);
      rd(IDX_TRACE, {traceIn[6:4], 3'b000, traceIn[3], 8'h00});
      chk(irq, 1'b0);
      wr(IDX_IRQMASK, 32'h7);
      tick(2);
      chk(irq, 1'b1);
      wr(IDX_IRQSTAT, 32'h7);
      rd(IDX_IRQSTAT, 0);
      chk(irq, 1'b0);
      {pwrupSetErr, startSetErr, runSetErr, portPeriphChg, portSerialChg} <= 5'h0;
      for (int k = 0; k < 5; k++) begin
         a = {$random(seed)} % 16;
         x = k == 0 ? bcd(a) : k == 1 ? bcd(a + 80) : k == 2 ? 16'hf0 : k == 3 ? 16'hf1 : 16'hff;
         busErr <= 1'b1;
         busErrKind <= pss_buserr_t'(k);
         busErrWord <= 4'(a);
         scan(1);
         busErr <= 1'b0;
         rd(IDX_ERRCODE, {16'h0, x[7:0], 8'h00});
      end
      rd(IDX_IRQSTAT, 32'h10);
      running <= 1'b1;
      for (int m = 0; m < 4; m++) begin
         wr(IDX_MONSET, m);
         scan(79);
         scan(79);
         rdn(IDX_CURCYC, 80 / ut[m]);
      end
      rdn(IDX_MAXCYC, 80 / ut[0]);
      rd(IDX_ERRCODE, 32'hff00);
      wr(IDX_LIMIT, 32'h0004);
      wr(IDX_IRQMASK, 32'h8);
      scan(79);
      rd(IDX_ERRCODE, 32'hff20);
      chk(irq, 1'b1);
      running <= 1'b0;
      tick(200);
      rdn(IDX_CURCYC, 5);
      test_done();
   end
endmodule : plc_system_status_words_test
